// ### inc/adc_map.vh
`ifndef ADC_MAP_VH
`define ADC_MAP_VH

// word indices on the register bus (byte address = 4 * index)
`define REG_STATUS_CONTROL  2'h0
`define REG_RESULT          2'h1
`define REG_CLOCK_CONFIG    2'h2

// status_control_register fields
`define SC_DONE_BIT         7
`define SC_IRQ_EN_BIT       6
`define SC_CONT_BIT         5
`define SC_CHAN_HI          4
`define SC_CHAN_LO          0

// clock_config_register fields
`define CC_DIV_HI           7
`define CC_DIV_LO           5
`define CC_SRC_BIT          4

// reset values
`define SC_CHAN_RESET       5'h1F
`define CC_DIV_RESET        3'h0
`define CC_SRC_RESET        1'h0

// channel codes
`define CHAN_EXT_LAST       5'h07
`define CHAN_REF_HIGH       5'h1D
`define CHAN_REF_LOW        5'h1E
`define CHAN_POWER_OFF      5'h1F

// prescaler terminal counts (ratio - 1)
`define DIV_LIM_1           4'h0
`define DIV_LIM_2           4'h1
`define DIV_LIM_4           4'h3
`define DIV_LIM_8           4'h7
`define DIV_LIM_16          4'hF

// conversion timing in converter clock ticks: one sample, two per bit
`define SAR_LAST_STEP       5'h10
`define SAR_MSB_TRIAL       8'h80
`define SAR_LAST_BIT        3'h7

`endif

// ### sim/adc_analog_model.sv
`timescale 1ns/10ps
// ideal mux plus comparator; one flop stands in for analog settling
module adc_analog_model (
  input  wire logic        clk,
  input  wire logic [4:0]  analog_select,
  input  wire logic        converter_power_down,
  input  wire logic [7:0]  trial_code,
  input  wire logic [63:0] levels,
  output logic             comparator_high
);
  logic junk = 1'b0;
  // unpowered or reserved inputs give a toggling, meaningless answer
  always @(posedge clk) begin
    junk <= ~junk;
    if (converter_power_down)
      comparator_high <= junk;
    else if (analog_select < 5'h08)
      comparator_high <= levels[analog_select*8 +: 8] >= trial_code;
    else if (analog_select == 5'h1D)
      comparator_high <= 1'b1;
    else if (analog_select == 5'h1E)
      comparator_high <= trial_code == 8'h00;
    else
      comparator_high <= junk;
  end
endmodule // adc_analog_model

// ### sim/adc_ctl_chk_sva.sv
`timescale 1ns/10ps
// timing relations seen at the converter block's ports
module adc_ctl_chk (
  input wire logic        clk,
  input wire logic        clk_en,
  input wire logic        rst_b,
  input wire logic [1:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [4:0]  analog_select,
  input wire logic        converter_power_down,
  input wire logic        sample_hold,
  input wire logic        irq,
  input wire logic [7:0]  port_analog_mask,
  input wire logic [7:0]  port_read_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // request seen, and accepted read of the result word
  sequence acc_s;
    clk_en && avs_waitrequest && (avs_read || avs_write);
  endsequence
  sequence rd_res_s;
    clk_en && !avs_waitrequest && avs_read && avs_address == 2'h1;
  endsequence
  // channel held long enough for derived outputs to settle
  sequence chan_calm_s;
    $stable(analog_select) [*3];
  endsequence
  bus_answer_a: assert property (acc_s |=> !avs_waitrequest)
    else $error("bus request not answered");
  wait_one_a: assert property (clk_en && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  irq_read_a: assert property (rd_res_s |=> !irq)
    else $error("irq kept after result read");
  power_down_a: assert property (chan_calm_s |->
    converter_power_down == (analog_select == 5'h1F))
    else $error("power down mismatch");
  no_sample_a: assert property (chan_calm_s ##0 converter_power_down |->
    !sample_hold) else $error("sampling while off");
  pin_mask_a: assert property (chan_calm_s |-> port_analog_mask ==
    (analog_select[4:3] == 2'h0 ? 8'h01 << analog_select[2:0] : 8'h00))
    else $error("pin mask wrong");
  pin_zero_a: assert property ($stable(port_analog_mask) |->
    (port_read_data & port_analog_mask) == 8'h00)
    else $error("owned pin reads one");
  read_high_a: assert property (!avs_waitrequest |->
    avs_readdata[31:8] == 24'h0) else $error("read data upper bits set");
endmodule // adc_ctl_chk

bind adc_sequencer_control adc_ctl_chk adc_ctl_chk_inst (.clk, .clk_en,
  .rst_b, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .analog_select, .converter_power_down, .sample_hold,
  .irq, .port_analog_mask, .port_read_data);

// ### sim/test_adc_sequencer_control.sv
`timescale 1ns/10ps
module test_adc_sequencer_control;
  logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, osc = 0;
  logic stop_mode = 0, p, clk_en = 1;
  logic [3:0]  be = 4'hF;
  logic [1:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0;
  logic [7:0]  port_pins_in = 0, q;
  logic [63:0] levels = 0;
  logic [4:0]  ch;
  wire  [31:0] avs_readdata;
  wire  [7:0]  trial_code, port_analog_mask, port_read_data;
  wire  [4:0]  analog_select;
  wire         avs_waitrequest, comparator_high, converter_power_down;
  wire         sample_hold, irq;
  int fails = 0, total_checks = 0, lvl[8], n, r, k;

  adc_sequencer_control adc_sequencer_control_inst (.clk, .clk_en,
    .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(be), .avs_readdata, .avs_waitrequest,
    .oscillator_output_clock(osc), .stop_mode, .comparator_high,
    .port_pins_in, .analog_select, .converter_power_down, .trial_code,
    .sample_hold, .irq, .port_analog_mask, .port_read_data);
  adc_analog_model adc_analog_model_inst (.clk, .analog_select,
    .converter_power_down, .trial_code, .levels, .comparator_high);

  // bus clock 200 MHz, oscillator 12 bus cycles per period
  initial forever #2.5 clk = ~clk;
  initial forever #30 osc = ~osc;

  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task chk_rng(input string s, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      fails++;
      $display("mismatch %s exp %0d..%0d got %0d", s, lo, hi, g);
    end
  endtask
  // one Avalon access; request held until waitrequest is seen low
  task bus(input logic wr, input logic [1:0] a, input logic [7:0] d);
    int w;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (avs_waitrequest !== 1'b0 && w < 50);
    q = avs_readdata[7:0];
    if (w == 50) begin
      fails++;
      $display("mismatch waitrequest exp 0 got 1");
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  // counts sample steps, i.e. conversion starts, over a window
  task count_smp(input int cyc);
    n = 0;
    p = 1'b0;
    repeat (cyc) begin
      @(posedge clk);
      if (sample_hold === 1'b1 && !p) n++;
      p = sample_hold;
    end
  endtask
  function automatic logic [7:0] expect_res(input logic [4:0] c);
    return c < 5'h08 ? lvl[c[2:0]] : (c == 5'h1D ? 8'hFF : 8'h00);
  endfunction
  task conclude;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    conclude();
  end

  initial begin
    void'($urandom(49142));
    for (int i = 0; i < 8; i++) begin
      lvl[i] = $urandom_range(255);
      levels[i*8 +: 8] = lvl[i];
    end
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    bus(0, 0, 0); chk("status", 8'h1F, q);
    bus(0, 2, 0); chk("clkcfg", 8'h00, q);
    bus(0, 3, 0); chk("unmapped", 8'h00, q);
    // a write without the low byte lane must leave the register alone
    be <= 4'hE;
    bus(1, 2, 8'hF0);
    be <= 4'hF;
    bus(0, 2, 0); chk("lane off", 8'h00, q);
    $display("test reset done");
    // every prescaler code on the bus clock, interrupt mode
    for (int c = 0; c < 8; c++) begin
      r = c > 3 ? 16 : 1 << c;
      bus(1, 2, {c[2:0], 5'h10});
      bus(1, 0, 8'h43);
      wait_irq(); chk_rng("ticks", 16*r, 17*r+12, n);
      bus(0, 0, 0); chk("irq mode flag", 8'h43, q);
      bus(0, 1, 0);
      if (r >= 8) chk("result", lvl[3], q);
      @(posedge clk); chk("irq read", 8'h00, {7'h0, irq});
    end
    bus(1, 2, 8'h00);
    bus(1, 0, 8'h43);
    wait_irq(); chk_rng("osc ticks", 192, 216, n);
    bus(1, 0, 8'h5F);
    @(posedge clk); chk("irq write", 8'h00, {7'h0, irq});
    $display("test prescaler done");
    // flag mode on a random pin and both references
    // eight bus cycles per tick leaves the comparator path time to settle
    bus(1, 2, 8'h70);
    port_pins_in <= 8'hFF;
    bus(1, 0, 8'h00); repeat (200) @(posedge clk); bus(0, 1, 0);
    for (int j = 0; j < 3; j++) begin
      ch = j == 0 ? 5'($urandom_range(7)) : (j == 1 ? 5'h1D : 5'h1E);
      bus(1, 0, {3'h0, ch});
      k = 0;
      do begin
        bus(0, 0, 0);
        k++;
      end while (q[7] !== 1'b1 && k < 200);
      chk("done set", {3'h4, ch}, q);
      bus(0, 1, 0); chk("result", expect_res(ch), q);
      bus(0, 0, 0); chk("done clear", {3'h0, ch}, q);
      if (j == 0) chk("pins", 8'hFF ^ (8'h01 << ch), port_read_data);
      repeat (200) @(posedge clk);
      bus(0, 0, 0); chk("single", {3'h0, ch}, q);
    end
    $display("test flag done");
    // restart in mid conversion
    bus(1, 0, 8'h41);
    repeat (40) @(posedge clk);
    bus(1, 0, 8'h42);
    wait_irq(); chk_rng("restart", 128, 148, n);
    bus(0, 1, 0); chk("restart result", lvl[2], q);
    $display("test restart done");
    // clock enable low for 100 cycles stretches the conversion by as much
    bus(1, 0, 8'h43);
    repeat (20) @(posedge clk);
    clk_en <= 1'b0;
    repeat (100) @(posedge clk);
    clk_en <= 1'b1;
    wait_irq(); chk_rng("frozen", 228, 248, n + 120);
    bus(0, 1, 0); chk("frozen result", lvl[3], q);
    $display("test enable done");
    // continuous, then stop mode, then power off
    bus(1, 0, 8'h24);
    count_smp(500); chk_rng("continuous", 3, 4, n);
    bus(0, 1, 0); chk("cont result", lvl[4], q);
    stop_mode <= 1'b1;
    repeat (10) @(posedge clk);
    count_smp(300); chk_rng("stopped", 0, 0, n);
    stop_mode <= 1'b0;
    count_smp(300); chk_rng("resumed", 2, 3, n);
    bus(1, 0, 8'h1F);
    count_smp(300); chk_rng("off", 0, 0, n);
    $display("test continuous done");
    // reset in mid run clears the flag, the modes and the clock settings
    bus(1, 0, 8'h24);
    repeat (200) @(posedge clk);
    bus(0, 0, 0); chk("cont flag", 8'hA4, q);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    bus(0, 0, 0); chk("reset status", 8'h1F, q);
    bus(0, 2, 0); chk("reset clkcfg", 8'h00, q);
    $display("test reset in run done");
    conclude();
  end
endmodule // test_adc_sequencer_control

// ### src/adc_clock_divider.v
`timescale 1ns/10ps
`include "adc_map.vh"

// prescaler: one output tick per 1, 2, 4, 8 or 16 input ticks
module adc_clock_divider (
  input  wire       clk,
  input  wire       rst_sync_b,
  input  wire       clk_en,
  input  wire       restart,
  input  wire       tick_in,
  input  wire [2:0] div_sel,
  output reg        tick_out
);

  reg  [3:0] cnt_q;
  reg  [3:0] lim;

  // any code with the top bit set divides by sixteen
  always @* begin
    case (div_sel)
      3'h0:    lim = `DIV_LIM_1;
      3'h1:    lim = `DIV_LIM_2;
      3'h2:    lim = `DIV_LIM_4;
      3'h3:    lim = `DIV_LIM_8;
      default: lim = `DIV_LIM_16;
    endcase
  end

  // restart aligns the first tick to the start of a conversion
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cnt_q    <= 4'h0;
      tick_out <= 1'h0;
    end else if (clk_en) begin
      if (restart) begin
        cnt_q    <= 4'h0;
        tick_out <= 1'h0;
      end else begin
        tick_out <= tick_in && (cnt_q >= lim);
        if (tick_in)
          cnt_q <= (cnt_q >= lim) ? 4'h0 : cnt_q + 4'h1;
      end
    end
  end

endmodule // adc_clock_divider

// ### src/adc_sar_engine.v
`timescale 1ns/10ps
`include "adc_map.vh"

// successive approximation sequencer, one step per converter tick
module adc_sar_engine (
  input  wire       clk,
  input  wire       rst_sync_b,
  input  wire       clk_en,
  input  wire       start,
  input  wire       abort,
  input  wire       tick,
  input  wire       comp_high,
  output reg        busy,
  output reg        done,
  output reg        sample,
  output reg  [7:0] trial_code,
  output reg  [7:0] result
);

  reg  [4:0] step_q;
  reg  [2:0] bit_q;
  wire [7:0] mask = `SAR_MSB_TRIAL >> bit_q;
  wire [7:0] kept = comp_high ? trial_code : (trial_code & ~mask);

  // step 0 samples, odd steps present a trial, even steps decide
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      busy       <= 1'h0;
      done       <= 1'h0;
      sample     <= 1'h0;
      step_q     <= 5'h00;
      bit_q      <= 3'h0;
      trial_code <= 8'h00;
      result     <= 8'h00;
    end else if (clk_en) begin
      done <= 1'h0;
      if (abort) begin
        busy   <= 1'h0;           // partial result is dropped
        sample <= 1'h0;
      end else if (start) begin
        busy       <= 1'h1;       // restart wins over a running one
        sample     <= 1'h1;
        step_q     <= 5'h00;
        bit_q      <= 3'h0;
        trial_code <= 8'h00;
      end else if (busy && tick) begin
        step_q <= step_q + 5'h01;
        if (step_q == 5'h00) begin
          sample     <= 1'h0;
          trial_code <= `SAR_MSB_TRIAL; // msb first
        end else if (!step_q[0]) begin
          // latch the decision, then offer the next lower bit
          if (bit_q == `SAR_LAST_BIT) begin
            result     <= kept;     // refreshed on every completion
            trial_code <= kept;
            done       <= 1'h1;
            busy       <= 1'h0;     // 17 ticks in all
          end else begin
            trial_code <= kept | (mask >> 1);
            bit_q      <= bit_q + 3'h1;
          end
        end
      end
    end
  end

endmodule // adc_sar_engine

// ### src/adc_sequencer_control.v
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "adc_map.vh"

// Overview of operation
// - without interrupts, done flag sets per conversion, cleared by result read
// - with interrupts enabled, done flag never sets and reads zero
// - with interrupts enabled, request raised at end of each conversion
// - request dropped on result read or status register write
// - reset clears the interrupt enable
// - continuous mode converts back to back; reset clears the mode bit
// - single mode does one conversion per status register write
// - five-bit channel field; codes 0 to 7 select external inputs
// - all-ones channel code powers down and stops conversions
// - codes 11101 and 11110 route high and low references
// - reserved channel codes give an undefined result
// - eight-bit result register refreshed at every completion
// - three-bit prescaler divides by 1, 2, 4, 8 or 16
// - source bit picks bus clock (1) or oscillator (0); reset oscillator
// - conversion begins after status write and lasts 16 or 17 ticks
// - continuous mode overwrites the result whether read or not
// - stop mode aborts conversion and holds the block idle
// - the selected pin is forced analog and reads back zero
module adc_sequencer_control (
  input  wire        clk,
  input  wire        clk_en,
  input  wire        rst_b,
  input  wire [1:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        oscillator_output_clock,
  input  wire        stop_mode,
  input  wire        comparator_high,
  input  wire [7:0]  port_pins_in,
  output reg  [4:0]  analog_select,
  output reg         converter_power_down,
  output wire [7:0]  trial_code,
  output wire        sample_hold,
  output reg         irq,
  output reg  [7:0]  port_analog_mask,
  output reg  [7:0]  port_read_data
);

  // reset release through two flops; assertion stays asynchronous
  reg         rst_s1_q;
  reg         rst_sync_b;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q   <= 1'h0;
      rst_sync_b <= 1'h0;
    end else begin
      rst_s1_q   <= 1'h1;
      rst_sync_b <= rst_s1_q;
    end
  end

  // register state
  reg         irq_en_q;
  reg         cont_q;
  reg         done_flag_q;
  reg  [2:0]  div_q;
  reg         src_q;
  reg         start_q;
  reg  [1:0]  seq_q;

  // pin inputs: comparator, oscillator clock and port pins
  reg  [9:0]  sync1_q;
  reg  [9:0]  sync2_q;
  reg  [9:0]  sync3_q;
  reg  [9:0]  filt_q;
  reg         osc_tick_q;
  wire [9:0]  pin_raw = {comparator_high, oscillator_output_clock,
                         port_pins_in};
  wire [9:0]  agree   = ~(sync2_q ^ sync3_q);

  // a change counts only once the second and third stage agree
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sync1_q    <= 10'h000;
      sync2_q    <= 10'h000;
      sync3_q    <= 10'h000;
      filt_q     <= 10'h000;
      osc_tick_q <= 1'h0;
    end else if (clk_en) begin
      sync1_q    <= pin_raw;
      sync2_q    <= sync1_q;
      sync3_q    <= sync2_q;
      filt_q     <= (sync3_q & agree) | (filt_q & ~agree);
      osc_tick_q <= agree[8] && sync3_q[8] && !filt_q[8];
    end
  end

  wire        comp_filt = filt_q[9];
  wire [7:0]  pins_filt = filt_q[7:0];

  // bus handshake: waitrequest idles high, drops for one cycle per request
  wire        req     = avs_read || avs_write;
  wire        acc     = clk_en && req && !avs_waitrequest;
  wire        wr_acc  = acc && avs_write && avs_byteenable[0];
  wire        rd_acc  = acc && avs_read;
  wire        sc_wr   = wr_acc && (avs_address == `REG_STATUS_CONTROL);
  wire        cc_wr   = wr_acc && (avs_address == `REG_CLOCK_CONFIG);
  wire        res_rd  = rd_acc && (avs_address == `REG_RESULT);
  wire [4:0]  wr_chan = avs_writedata[`SC_CHAN_HI:`SC_CHAN_LO];

  // converter engine hookup
  wire        eng_busy;
  wire        eng_done;
  wire [7:0]  eng_result;
  wire        adc_tick;
  wire        powered_on = (analog_select != `CHAN_POWER_OFF);
  // the bus clock feeds one tick per cycle, the oscillator one per rising edge
  wire        pre_tick   = src_q ? 1'h1 : osc_tick_q;
  // abort on stop, on power off, and on any status write
  wire        abort      = stop_mode || !powered_on || sc_wr;

  adc_clock_divider u_div (
    .clk        (clk),
    .rst_sync_b (rst_sync_b),
    .clk_en     (clk_en),
    .restart    (start_q),
    .tick_in    (pre_tick),
    .div_sel    (div_q),
    .tick_out   (adc_tick)
  );

  adc_sar_engine u_sar (
    .clk        (clk),
    .rst_sync_b (rst_sync_b),
    .clk_en     (clk_en),
    .start      (start_q),
    .abort      (abort),
    .tick       (adc_tick),
    .comp_high  (comp_filt),
    .busy       (eng_busy),
    .done       (eng_done),
    .sample     (sample_hold),
    .trial_code (trial_code),
    .result     (eng_result)
  );

  // status and clock registers; the done flag bit is not writable
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_en_q      <= 1'h0;
      cont_q        <= 1'h0;
      analog_select <= `SC_CHAN_RESET;
      div_q         <= `CC_DIV_RESET;
      src_q         <= `CC_SRC_RESET;
    end else if (clk_en) begin
      if (sc_wr) begin
        irq_en_q      <= avs_writedata[`SC_IRQ_EN_BIT];
        cont_q        <= avs_writedata[`SC_CONT_BIT];
        analog_select <= wr_chan;
        // written bit 7 is dropped, so a stray one does no harm
      end
      if (cc_wr) begin
        div_q <= avs_writedata[`CC_DIV_HI:`CC_DIV_LO];
        src_q <= avs_writedata[`CC_SRC_BIT];
      end
    end
  end

  // sequencer states: decides when the engine is (re)started
  localparam [1:0] SEQ_IDLE = 2'h0;  // waiting for a status write
  localparam [1:0] SEQ_CONV = 2'h1;  // a conversion is under way
  localparam [1:0] SEQ_HALT = 2'h2;  // stop mode; continuous resumes on exit
  reg  [1:0]  seq_d;
  reg         start_d;

  // start goes out one cycle after its cause, so the engine sees the new
  // settings; stop mode blocks every start until it is left
  always @* begin
    seq_d   = seq_q;
    start_d = 1'h0;
    case (seq_q)
      SEQ_IDLE: begin
        if (stop_mode) begin
          seq_d = SEQ_HALT;
        end else if (sc_wr && (wr_chan != `CHAN_POWER_OFF)) begin
          start_d = 1'h1;
          seq_d   = SEQ_CONV;
        end
      end
      SEQ_CONV: begin
        if (stop_mode) begin
          seq_d = SEQ_HALT;
        end else if (sc_wr) begin
          // a write mid conversion starts over with the new settings
          start_d = (wr_chan != `CHAN_POWER_OFF);
          seq_d   = (wr_chan != `CHAN_POWER_OFF) ? SEQ_CONV : SEQ_IDLE;
        end else if (!powered_on) begin
          seq_d = SEQ_IDLE;
        end else if (eng_done) begin
          start_d = cont_q;
          seq_d   = cont_q ? SEQ_CONV : SEQ_IDLE;
        end else if (!eng_busy && !start_q) begin
          seq_d = SEQ_IDLE;
        end
      end
      SEQ_HALT: begin
        if (!stop_mode) begin
          // leaving stop: a write wins, else continuous mode resumes
          if (sc_wr)
            start_d = (wr_chan != `CHAN_POWER_OFF);
          else
            start_d = cont_q && powered_on;
          seq_d = start_d ? SEQ_CONV : SEQ_IDLE;
        end
      end
      default: begin
        seq_d = SEQ_IDLE;
      end
    endcase
  end

  // sequencer state and the one-cycle start strobe
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      seq_q   <= SEQ_IDLE;
      start_q <= 1'h0;
    end else if (clk_en) begin
      seq_q   <= seq_d;
      start_q <= start_d;
    end
  end

  // flag and request: a completion in the clearing cycle wins
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      done_flag_q <= 1'h0;
      irq         <= 1'h0;
    end else if (clk_en) begin
      if (eng_done && !irq_en_q)
        done_flag_q <= 1'h1;
      else if (res_rd)
        done_flag_q <= 1'h0;
      if (eng_done && irq_en_q)
        irq <= 1'h1;
      else if (res_rd || sc_wr)
        irq <= 1'h0;
    end
  end

  // read byte of the addressed register; the unmapped index reads zero
  reg  [7:0]  rd_byte_d;

  always @* begin
    case (avs_address)
      `REG_STATUS_CONTROL:
        rd_byte_d = {done_flag_q && !irq_en_q, irq_en_q, cont_q,
                     analog_select};
      `REG_RESULT:
        rd_byte_d = eng_result;
      `REG_CLOCK_CONFIG:
        rd_byte_d = {div_q, src_q, 4'h0};
      default:
        rd_byte_d = 8'h00;
    endcase
  end

  // bus slave: read data is latched as waitrequest drops
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      avs_waitrequest <= 1'h1;
      avs_readdata    <= 32'h00000000;
    end else if (clk_en) begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (req && avs_waitrequest && avs_read)
        avs_readdata <= {24'h000000, rd_byte_d};
    end
  end

  // only codes 0 to 7 own a port pin; reference and reserved own none
  reg  [7:0]  pin_mask_d;

  always @* begin
    pin_mask_d = 8'h00;
    if (analog_select <= `CHAN_EXT_LAST)
      pin_mask_d = 8'h01 << analog_select[2:0];
  end

  // pin ownership and power; reference codes carry no pin
  always @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      converter_power_down <= 1'h1;
      port_analog_mask     <= 8'h00;
      port_read_data       <= 8'h00;
    end else if (clk_en) begin
      converter_power_down <= !powered_on;
      port_analog_mask     <= pin_mask_d;
      port_read_data <= pins_filt & ~port_analog_mask;
    end
  end

endmodule // adc_sequencer_control
